// ---- hw/mwp_deglitch.sv ----
// Purpose: Two-flop synchroniser and stability filter for one pin
// Assumes: Filter length given in core cycles
// Notes: Output moves only after the input held steady for len cycles
`timescale 1ns/100ps
module mwp_deglitch #(
    parameter logic INIT = 1'b0
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic raw_in,
    input wire logic [9:0] len_in,
    output logic flt_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [9:0] cnt;
        logic flt;
    } mwp_dgl_t;

    mwp_dgl_t q;
    mwp_dgl_t d;

    always_comb begin
        d = q;
        d.s1 = raw_in;
        d.s2 = q.s1;
        if (q.s2 == q.flt) begin
            d.cnt = 10'h000;
        end else if (q.cnt + 10'h001 >= len_in) begin
            d.flt = q.s2;
            d.cnt = 10'h000;
        end else begin
            d.cnt = q.cnt + 10'h001;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '{s1: INIT, s2: INIT, cnt: 10'h000, flt: INIT};
        end else begin
            q <= d;
        end
    end

    assign flt_out = q.flt;

    steady_flt_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $changed(q.flt) |-> $past(q.cnt) + 10'h001 >= $past(len_in))
        else $error("filter output moved before input was steady");

endmodule : mwp_deglitch

// ---- hw/mwp_pkg.sv ----
// Purpose: Shared constants for the motion wake pulse interface
// Assumes: 100 MHz core clock
// Notes: Times kept in their own unit, counts derived from them
package mwp_pkg;

    localparam int CLK_NS = 10;
    localparam int US_NS = 1000;
    localparam logic [6:0] TICK_CYC = 7'(US_NS / CLK_NS);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Filter times
    localparam int DGL_MOT_NS = 10000;
    localparam logic [9:0] DGL_MOT_CYC = 10'(DGL_MOT_NS / CLK_NS);
    localparam int WAKE_FLT_NS = 400;
    localparam logic [9:0] WAKE_FLT_CYC = 10'(WAKE_FLT_NS / CLK_NS);
    localparam int HIB_FLT_NS = 850;
    localparam logic [9:0] HIB_FLT_CYC = 10'(HIB_FLT_NS / CLK_NS);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Threshold pulse ranges, least rounded up, longest rounded down
    localparam int THR1_MIN_NS = 562500;
    localparam int THR1_MAX_NS = 883000;
    localparam int THR2_MIN_NS = 1125000;
    localparam int THR2_MAX_NS = 1570000;
    localparam int THR3_MIN_NS = 2250000;
    localparam int THR3_MAX_NS = 2950000;
    localparam logic [12:0] THR1_MIN_US = 13'((THR1_MIN_NS + US_NS - 1) / US_NS);
    localparam logic [12:0] THR1_MAX_US = 13'(THR1_MAX_NS / US_NS);
    localparam logic [12:0] THR2_MIN_US = 13'((THR2_MIN_NS + US_NS - 1) / US_NS);
    localparam logic [12:0] THR2_MAX_US = 13'(THR2_MAX_NS / US_NS);
    localparam logic [12:0] THR3_MIN_US = 13'((THR3_MIN_NS + US_NS - 1) / US_NS);
    localparam logic [12:0] THR3_MAX_US = 13'(THR3_MAX_NS / US_NS);
    localparam logic [1:0] THR_RESET = 2'h1;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pulse widths and boot timing
    localparam logic [13:0] SAMPLE_READY_PULSE_US = 14'h0020;
    localparam logic [13:0] BOOT1_PULSE_US = 14'h0040;
    localparam logic [20:0] BOOT_WAIT_US = 21'h0001f4;
    localparam int TON_NS = 528500;
    localparam logic [20:0] TON_US = 21'((TON_NS + US_NS - 1) / US_NS);
    localparam logic [27:0] TON_FRAC_MUL = 28'h0000069;
    localparam int TON_FRAC_SH = 16;

    // Check limits in cycles
    localparam int SAMPLE_READY_PULSE_MIN_CYC = 29000 / CLK_NS;
    localparam int SAMPLE_READY_PULSE_MAX_CYC = 35600 / CLK_NS;
    localparam int BOOT1_MIN_CYC = 58000 / CLK_NS;
    localparam int BOOT1_MAX_CYC = 71200 / CLK_NS;
    localparam int BOOT2_MIN_CYC = 9000000 / CLK_NS;
    localparam int BOOT2_MAX_CYC = 11200000 / CLK_NS;
    localparam int MOT_MIN_CYC = 4550000 / CLK_NS;
    localparam int MOT_MAX_CYC = 5560000 / CLK_NS;
    localparam int STBY_MAX_CYC = 1000000 / CLK_NS;
    localparam int MOTB_MAX_CYC = 17700000 / CLK_NS;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] PERIOD_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_HIB_BIT = 1;
    localparam int CTRL_LPM_BIT = 2;
    localparam int CTRL_DEC_LSB = 4;
    localparam int CTRL_SOFT_BIT = 8;
    localparam int STAT_THR_LSB = 3;
    localparam int STAT_STRAP_BIT = 5;
    localparam int STAT_LINE_BIT = 6;
    localparam logic [20:0] PERIOD_RESET = 21'h002710;

    typedef enum logic [2:0] {
        MWP_BOOT = 3'h0,
        MWP_BPULSE = 3'h1,
        MWP_STANDBY = 3'h2,
        MWP_WAKE = 3'h3,
        MWP_ACTIVE = 3'h4,
        MWP_HIB = 3'h5,
        MWP_WINDOW = 3'h6,
        MWP_MOTION = 3'h7
    } mwp_state_t;

endpackage : mwp_pkg

// ---- hw/mwp_pulse.sv ----
// Purpose: Timed pulse of a given length in microsecond ticks
// Assumes: tick_in is a one-cycle pulse once per microsecond
// Notes: Width is len-1 to len microseconds, a restart reloads it
`timescale 1ns/100ps
module mwp_pulse (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic [13:0] len_in,
    output logic busy_out
);
    typedef struct packed {
        logic [13:0] cnt;
    } mwp_pls_t;

    mwp_pls_t q;
    mwp_pls_t d;

    always_comb begin
        d = q;
        if (start_in) begin
            d.cnt = len_in;
        end else if (tick_in && q.cnt != 14'h0000) begin
            d.cnt = q.cnt - 14'h0001;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '{cnt: 14'h0000};
        end else begin
            q <= d;
        end
    end

    assign busy_out = q.cnt != 14'h0000;

endmodule : mwp_pulse

// ---- hw/mwp_top.sv ----
// Purpose: Boot, pulse timing and one-wire motion line sequencing
// Assumes: APB slave, zero wait states, one 100 MHz clock
// Notes: Motion line driven low only while a motion pulse runs
`timescale 1ns/100ps
// Notes on behaviour
// - After line goes high in motion boot, threshold window lasts 5 ms.
// - Host pulse 562.5 to 883 us selects motion threshold one.
// - Host pulse 1125 to 1570 us selects motion threshold two.
// - Host pulse 2250 to 2950 us selects motion threshold three.
// - Strap low: each new sample gives a 32 us ready pulse.
// - Boot done pulse: 64 us with strap low, 10 ms with strap high.
// - Motion boot: line deglitched, transitions under 10 us ignored.
// - Hibernate exit filters wake 400 ns or motion line 850 ns.
// - Strap low: standby reached within 1 ms of reset.
// - Strap and line high: motion mode reached within 17.7 ms.
// - First sample after 528.5 us plus decimation dependent extra time.
// - Low power mode forces decimation one.
// - Own interrupt pulse on line does not add to host hibernate low time.
// - Motion boot: detected motion drives a 5 ms pulse on line.
module mwp_top #(
    parameter int WIN_US = 5000,
    parameter int MOT_PULSE_US = 5000,
    parameter int BOOT2_PULSE_US = 10000,
    parameter int HIB_LOW_US = 910
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic boot_mode_strap_in,
    input wire logic wake_n_in,
    input wire logic motion_wire_in,
    output logic motion_wire_out,
    output logic motion_wire_oe_out,
    input wire logic motion_event_in,
    output logic sample_ready_pulse_out,
    output logic boot_done_out,
    output logic [1:0] motion_threshold_out
);
    typedef struct packed {
        mwp_pkg::mwp_state_t st;
        logic str1;
        logic str2;
        logic strap;
        logic [20:0] tmr;
        logic [12:0] width;
        logic [12:0] low;
        logic [1:0] thr;
        logic [6:0] tick;
        logic mf;
        logic active;
        logic hib_req;
        logic low_power_mode;
        logic [2:0] decimation_factor;
        logic [20:0] output_rate;
        logic [31:0] prdata;
    } mwp_top_t;

    mwp_top_t q;
    mwp_top_t d;
    logic tick;
    logic mflt;
    logic wflt;
    logic rise;
    logic fall;
    logic in_r1;
    logic in_r2;
    logic in_r3;
    logic [9:0] mlen;
    logic sample_ready_pulse_start;
    logic boot_start;
    logic mot_start;
    logic sample_ready_pulse_busy;
    logic boot_busy;
    logic mot_busy;
    logic [13:0] boot_len;
    logic [2:0] dlog;
    logic [27:0] xprod;
    logic [27:0] ydiv;
    logic [27:0] yfrac;
    logic [20:0] ton_us;
    logic wr_en;
    logic hit;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin filters and pulse generators
    assign mlen = (q.st == mwp_pkg::MWP_HIB && q.strap) ? mwp_pkg::HIB_FLT_CYC
                                                       : mwp_pkg::DGL_MOT_CYC;
    mwp_deglitch #(.INIT(1'b0)) u_mot_flt (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .raw_in(motion_wire_in),
        .len_in(mlen),
        .flt_out(mflt)
    );
    mwp_deglitch #(.INIT(1'b1)) u_wake_flt (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .raw_in(wake_n_in),
        .len_in(mwp_pkg::WAKE_FLT_CYC),
        .flt_out(wflt)
    );
    mwp_pulse u_sample_ready_pulse (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .tick_in(tick),
        .start_in(sample_ready_pulse_start),
        .len_in(mwp_pkg::SAMPLE_READY_PULSE_US),
        .busy_out(sample_ready_pulse_busy)
    );
    mwp_pulse u_boot (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .tick_in(tick),
        .start_in(boot_start),
        .len_in(boot_len),
        .busy_out(boot_busy)
    );
    mwp_pulse u_mot (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .tick_in(tick),
        .start_in(mot_start),
        .len_in(14'(MOT_PULSE_US)),
        .busy_out(mot_busy)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Decode and first sample delay
    assign tick = q.tick == mwp_pkg::TICK_CYC - 7'h01;
    assign rise = mflt && !q.mf;
    assign fall = !mflt && q.mf;
    assign in_r1 = q.width >= mwp_pkg::THR1_MIN_US && q.width <= mwp_pkg::THR1_MAX_US;
    assign in_r2 = q.width >= mwp_pkg::THR2_MIN_US && q.width <= mwp_pkg::THR2_MAX_US;
    assign in_r3 = q.width >= mwp_pkg::THR3_MIN_US && q.width <= mwp_pkg::THR3_MAX_US;
    assign boot_len = q.strap ? 14'(BOOT2_PULSE_US) : mwp_pkg::BOOT1_PULSE_US;
    assign dlog = q.low_power_mode ? 3'h0 : q.decimation_factor;
    assign xprod = ({7'h00, q.output_rate} << dlog) - {7'h00, q.output_rate};
    assign ydiv = xprod >> dlog;
    assign yfrac = (ydiv * mwp_pkg::TON_FRAC_MUL) >> mwp_pkg::TON_FRAC_SH;
    assign ton_us = mwp_pkg::TON_US + 21'(ydiv - yfrac);
    assign wr_en = psel_in && penable_in && pwrite_in;
    assign hit = paddr_in == mwp_pkg::CTRL_OFS || paddr_in == mwp_pkg::PERIOD_OFS
              || paddr_in == mwp_pkg::STATUS_OFS;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        sample_ready_pulse_start = 1'b0;
        boot_start = 1'b0;
        mot_start = 1'b0;
        d.str1 = boot_mode_strap_in;
        d.str2 = q.str1;
        d.mf = mflt;
        d.tick = tick ? 7'h00 : q.tick + 7'h01;
        if (rise) begin
            d.width = 13'h0000;
        end else if (tick && q.width != 13'h1fff) begin
            d.width = q.width + 13'h0001;
        end
        case (q.st)
            mwp_pkg::MWP_BOOT: begin
                d.strap = q.str2;
                if (tick) begin
                    d.tmr = q.tmr + 21'h000001;
                end
                if (q.tmr >= mwp_pkg::BOOT_WAIT_US) begin
                    d.tmr = 21'h000000;
                    if (q.strap) begin
                        d.st = mwp_pkg::MWP_WINDOW;
                    end else begin
                        d.st = mwp_pkg::MWP_BPULSE;
                        boot_start = 1'b1;
                    end
                end
            end
            mwp_pkg::MWP_WINDOW: begin
                if (tick && (mflt || q.tmr != 21'h000000)) begin
                    d.tmr = q.tmr + 21'h000001;
                end
                if (fall && in_r1) begin
                    d.thr = 2'h1;
                end else if (fall && in_r2) begin
                    d.thr = 2'h2;
                end else if (fall && in_r3) begin
                    d.thr = 2'h3;
                end
                if (q.tmr >= 21'(WIN_US)) begin
                    d.tmr = 21'h000000;
                    d.st = mwp_pkg::MWP_BPULSE;
                    boot_start = 1'b1;
                end
            end
            mwp_pkg::MWP_BPULSE: begin
                if (!boot_busy) begin
                    d.st = q.strap ? mwp_pkg::MWP_MOTION : mwp_pkg::MWP_STANDBY;
                end
            end
            mwp_pkg::MWP_STANDBY: begin
                d.tmr = 21'h000000;
                if (q.hib_req) begin
                    d.st = mwp_pkg::MWP_HIB;
                end else if (q.active) begin
                    d.st = mwp_pkg::MWP_WAKE;
                end
            end
            mwp_pkg::MWP_WAKE: begin
                if (tick) begin
                    d.tmr = q.tmr + 21'h000001;
                end
                if (!q.active) begin
                    d.st = mwp_pkg::MWP_STANDBY;
                end else if (q.tmr >= ton_us) begin
                    d.tmr = 21'h000000;
                    d.st = mwp_pkg::MWP_ACTIVE;
                    sample_ready_pulse_start = 1'b1;
                end
            end
            mwp_pkg::MWP_ACTIVE: begin
                if (tick) begin
                    d.tmr = q.tmr + 21'h000001;
                end
                if (!q.active) begin
                    d.st = mwp_pkg::MWP_STANDBY;
                end else if (tick && q.tmr + 21'h000001 >= q.output_rate) begin
                    d.tmr = 21'h000000;
                    sample_ready_pulse_start = 1'b1;
                end
            end
            mwp_pkg::MWP_HIB: begin
                if (q.strap ? mflt : !wflt) begin
                    d.st = q.strap ? mwp_pkg::MWP_MOTION : mwp_pkg::MWP_STANDBY;
                    d.hib_req = 1'b0;
                    d.low = 13'h0000;
                end
            end
            mwp_pkg::MWP_MOTION: begin
                if (mflt || mot_busy) begin
                    d.low = mflt ? 13'h0000 : q.low;
                end else if (tick) begin
                    d.low = q.low + 13'h0001;
                end
                if (q.low >= 13'(HIB_LOW_US)) begin
                    d.st = mwp_pkg::MWP_HIB;
                end else if (motion_event_in && !mot_busy) begin
                    mot_start = 1'b1;
                end
            end
            default: begin
                d.st = mwp_pkg::MWP_BOOT;
            end
        endcase
        if (psel_in && !penable_in) begin
            case (paddr_in)
                mwp_pkg::CTRL_OFS: begin
                    d.prdata = {25'h0000000, q.decimation_factor, 1'b0, q.low_power_mode,
                                q.hib_req, q.active};
                end
                mwp_pkg::PERIOD_OFS: begin
                    d.prdata = {11'h000, q.output_rate};
                end
                mwp_pkg::STATUS_OFS: begin
                    d.prdata = {25'h0000000, q.mf, q.strap, q.thr, q.st};
                end
                default: begin
                    d.prdata = 32'h00000000;
                end
            endcase
        end
        if (wr_en && paddr_in == mwp_pkg::CTRL_OFS) begin
            d.active = pwdata_in[mwp_pkg::CTRL_ACTIVE_BIT];
            d.hib_req = pwdata_in[mwp_pkg::CTRL_HIB_BIT];
            d.low_power_mode = pwdata_in[mwp_pkg::CTRL_LPM_BIT];
            d.decimation_factor = pwdata_in[mwp_pkg::CTRL_DEC_LSB +: 3];
            if (pwdata_in[mwp_pkg::CTRL_SOFT_BIT]) begin
                d.st = mwp_pkg::MWP_BOOT;
                d.tmr = 21'h000000;
                d.active = 1'b0;
                d.hib_req = 1'b0;
            end
        end
        if (wr_en && paddr_in == mwp_pkg::PERIOD_OFS) begin
            d.output_rate = pwdata_in[20:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '{st: mwp_pkg::MWP_BOOT, str1: 1'b0, str2: 1'b0, strap: 1'b0,
                   tmr: 21'h000000, width: 13'h0000, low: 13'h0000,
                   thr: mwp_pkg::THR_RESET, tick: 7'h00, mf: 1'b0, active: 1'b0,
                   hib_req: 1'b0, low_power_mode: 1'b0, decimation_factor: 3'h0,
                   output_rate: mwp_pkg::PERIOD_RESET, prdata: 32'h00000000};
        end else begin
            q <= d;
        end
    end

    assign prdata_out = q.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !hit;
    assign motion_wire_out = 1'b0;
    assign motion_wire_oe_out = mot_busy;
    assign sample_ready_pulse_out = sample_ready_pulse_busy;
    assign boot_done_out = boot_busy;
    assign motion_threshold_out = q.thr;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Check helpers
    function automatic logic [23:0] run_len(input logic lvl, input logic [23:0] cnt);
        run_len = lvl ? cnt + 24'h000001 : 24'h000000;
    endfunction : run_len

    logic [23:0] sample_ready_pulse_len;
    logic [23:0] boot_run;
    logic [23:0] mot_run;
    logic [23:0] boot_cyc;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sample_ready_pulse_len <= 24'h000000;
            boot_run <= 24'h000000;
            mot_run <= 24'h000000;
            boot_cyc <= 24'h000000;
        end else begin
            sample_ready_pulse_len <= run_len(sample_ready_pulse_busy, sample_ready_pulse_len);
            boot_run <= run_len(boot_busy, boot_run);
            mot_run <= run_len(mot_busy, mot_run);
            boot_cyc <= run_len(q.st == mwp_pkg::MWP_BOOT || q.st == mwp_pkg::MWP_BPULSE
                                || q.st == mwp_pkg::MWP_WINDOW, boot_cyc);
        end
    end

    default clocking mwp_cb @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    win_close_a: assert property (
        (q.st == mwp_pkg::MWP_WINDOW && q.tmr < 21'(WIN_US)) |=> q.st == mwp_pkg::MWP_WINDOW)
        else $error("threshold window closed early");
    thr_one_a: assert property (
        (q.st == mwp_pkg::MWP_WINDOW && fall && in_r1) |=> q.thr == 2'h1)
        else $error("threshold one not taken");
    thr_two_a: assert property (
        (q.st == mwp_pkg::MWP_WINDOW && fall && in_r2) |=> q.thr == 2'h2)
        else $error("threshold two not taken");
    thr_three_a: assert property (
        (q.st == mwp_pkg::MWP_WINDOW && fall && in_r3) |=> q.thr == 2'h3)
        else $error("threshold three not taken");
    sample_ready_pulse_width_a: assert property (
        $fell(sample_ready_pulse_busy) |-> sample_ready_pulse_len >= mwp_pkg::SAMPLE_READY_PULSE_MIN_CYC && sample_ready_pulse_len <= mwp_pkg::SAMPLE_READY_PULSE_MAX_CYC)
        else $error("sample ready pulse width wrong");
    boot_width_a: assert property (
        $fell(boot_busy) |-> (q.strap ? (boot_run >= mwp_pkg::BOOT2_MIN_CYC
            && boot_run <= mwp_pkg::BOOT2_MAX_CYC) : (boot_run >= mwp_pkg::BOOT1_MIN_CYC
            && boot_run <= mwp_pkg::BOOT1_MAX_CYC)))
        else $error("boot done pulse width wrong");
    wake_exit_a: assert property (
        (q.st == mwp_pkg::MWP_HIB && !q.strap && wflt) |=> q.st == mwp_pkg::MWP_HIB)
        else $error("hibernate left without filtered wake");
    stby_time_a: assert property (
        (q.st == mwp_pkg::MWP_STANDBY && $past(q.st) == mwp_pkg::MWP_BPULSE)
        |-> boot_cyc <= mwp_pkg::STBY_MAX_CYC)
        else $error("standby reached late");
    ton_first_a: assert property (
        (q.st == mwp_pkg::MWP_WAKE && q.active && q.tmr >= ton_us)
        |=> q.st == mwp_pkg::MWP_ACTIVE ##1 sample_ready_pulse_out)
        else $error("first sample not on time");
    lpm_dec_a: assert property (
        q.low_power_mode |-> dlog == 3'h0 && ton_us == mwp_pkg::TON_US)
        else $error("decimation not forced to one");
    hib_low_a: assert property (
        (q.st == mwp_pkg::MWP_HIB && $past(q.st) == mwp_pkg::MWP_MOTION)
        |-> $past(q.low) >= 13'(HIB_LOW_US))
        else $error("hibernate entered on short low time");
    mot_width_a: assert property (
        $fell(mot_busy) |-> mot_run >= mwp_pkg::MOT_MIN_CYC && mot_run <= mwp_pkg::MOT_MAX_CYC)
        else $error("motion pulse width wrong");
    thr_keep_a: assert property (
        $changed(q.thr) |-> $past(fall && (in_r1 || in_r2 || in_r3)) || $past(!reset_n_in))
        else $error("threshold changed without valid pulse");

    motion_boot_c: cover property (q.st == mwp_pkg::MWP_MOTION && $past(q.st) == mwp_pkg::MWP_BPULSE);
    sample_c: cover property ($rose(sample_ready_pulse_out) && q.st == mwp_pkg::MWP_ACTIVE);
    motion_hib_c: cover property (q.st == mwp_pkg::MWP_HIB && q.strap);
    thr_set_c: cover property ($changed(q.thr));

endmodule : mwp_top

// ---- test/motion_wake_pulse_interface_bench.sv ----
// Purpose: Self-checking bench for the motion wake pulse block
// Assumes: Default parameters, host model on the motion line
// Notes: Threshold rows first, boot and sample cases after
`timescale 1ns/100ps
module motion_wake_pulse_interface_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic strap = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, perr, err, line, oe, sample_ready_pulse, bdone, mwo;
    logic [1:0] thr;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int n, n0;
    typedef struct {int w; logic [1:0] t;} mwp_row_t;
    mwp_row_t rows[3] = '{'{1250, 2'h2}, '{2500, 2'h3}, '{1000, 2'h1}};
    mwp_top u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .boot_mode_strap_in(strap), .wake_n_in(1'b1),
        .motion_wire_in(line), .motion_wire_out(mwo), .motion_wire_oe_out(oe),
        .motion_event_in(1'b0), .sample_ready_pulse_out(sample_ready_pulse), .boot_done_out(bdone),
        .motion_threshold_out(thr));
    mwp_host_model u_host (.core_clk_in(clk), .dev_oe_in(oe), .line_out(line));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000000) begin
            fail_count++;
            results();
        end
    end
    //////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rst(input logic s);
        rst_n <= 1'b0;
        strap <= s;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
    endtask : rst
    task automatic width(ref logic s, output int k);
        k = 0;
        while (s !== 1'b1) @(posedge clk);
        while (s === 1'b1) begin
            k++;
            @(posedge clk);
        end
    endtask : width
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    //////////////////////////////////////////////////
    initial begin
        foreach (rows[i]) begin
            rst(1'b1);
            repeat (60000) @(posedge clk);
            u_host.pulse(rows[i].w);
            chk("threshold", 32'(rows[i].t), 32'(thr));
        end
        rst(1'b0);
        n0 = cyc;
        width(bdone, n);
        chk("boot_width", 1, 32'(n >= mwp_pkg::BOOT1_MIN_CYC && n <= mwp_pkg::BOOT1_MAX_CYC));
        repeat (mwp_pkg::STBY_MAX_CYC - (cyc - n0) - 3) @(posedge clk);
        apb(1'b0, mwp_pkg::STATUS_OFS, 32'h0);
        chk("state", 32'(mwp_pkg::MWP_STANDBY), {29'h0, rd[2:0]});
        apb(1'b0, 12'h00c, 32'h0);
        chk("bad_read", 32'h0, rd);
        chk("bad_err", 32'h1, 32'(err));
        apb(1'b0, mwp_pkg::PERIOD_OFS, 32'h0);
        chk("period", 32'(mwp_pkg::PERIOD_RESET), rd);
        chk("line_drive", 32'h0, {30'h0, oe, mwo});
        apb(1'b1, mwp_pkg::CTRL_OFS, 32'h35);
        n0 = cyc;
        width(sample_ready_pulse, n);
        chk("first_sample", 1, 32'(cyc - n0 - n >= 52850 && cyc - n0 - n <= 53100));
        chk("ready_width", 1, 32'(n >= mwp_pkg::SAMPLE_READY_PULSE_MIN_CYC && n <= mwp_pkg::SAMPLE_READY_PULSE_MAX_CYC));
        results();
    end
endmodule : motion_wake_pulse_interface_bench

// ---- test/mwp_host_model.sv ----
// Purpose: Host side of the shared motion line
// Assumes: Line pulled up, device only pulls low
// Notes: Host timing in core cycles
`timescale 1ns/100ps
module mwp_host_model (
    input wire logic core_clk_in,
    input wire logic dev_oe_in,
    output logic line_out
);
    logic level_q = 1'b1;
    assign line_out = level_q & ~dev_oe_in;
    task automatic pulse(input int width_us);
        @(posedge core_clk_in);
        level_q <= 1'b0;
        repeat (5000) @(posedge core_clk_in);
        level_q <= 1'b1;
        repeat (width_us * 100) @(posedge core_clk_in);
        level_q <= 1'b0;
        repeat (2000) @(posedge core_clk_in);
        level_q <= 1'b1;
    endtask : pulse
    task automatic hib_cmd(input int low_us);
        @(posedge core_clk_in);
        level_q <= 1'b0;
        repeat (low_us * 100) @(posedge core_clk_in);
        level_q <= 1'b1;
    endtask : hib_cmd
endmodule : mwp_host_model
